// >>> logic/cpc_top.sv
/*
  Cell protection controller: drives the charge and discharge FET enables
  from synchronised comparator results, holds the protection, status,
  memory control and special feature registers, and the shadowed,
  lockable memory blocks, all reached through a decoded host command port.
  Assumes comparator inputs are asynchronous levels and the host command
  port is driven by logic on mclk.
*/
`timescale 1ns/1ns
module cpc_top
#(
  parameter int unsigned CELL_HIGH_CYC = cpc_pkg::CPC_CELL_HIGH_CYC,
  parameter int unsigned CELL_LOW_CYC  = cpc_pkg::CPC_CELL_LOW_CYC,
  parameter int unsigned DEPLETION_CYC = cpc_pkg::CPC_DEPLETION_CYC,
  parameter int unsigned FET_DROP_CYC  = cpc_pkg::CPC_FET_DROP_CYC,
  parameter int unsigned COPY_CYC      = cpc_pkg::CPC_COPY_CYC
)
(
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic            cell_above_high,
  input  wire logic            cell_below_resume,
  input  wire logic            cell_below_low,
  input  wire logic            cell_below_depletion,
  input  wire logic            fet_drop_high,
  input  wire logic            pack_recovered,
  input  wire logic            charger_present,
  input  wire logic            die_overtemp,
  input  wire logic            wake_switch_input_n,
  input  wire logic            cmd_valid,
  input  cpc_pkg::cpc_op_e     cmd_op,
  input  wire logic [7:0]      cmd_addr,
  input  wire logic [7:0]      cmd_wdata,
  output logic                 rsp_valid,
  output logic      [7:0]      rsp_rdata,
  output logic                 charge_drive,
  output logic                 discharge_drive,
  output logic                 probe_current_en,
  output logic                 recovery_charge_en,
  output logic                 active_mode
);
  import cpc_pkg::*;

  // Is the address inside one of the two memory blocks
  function automatic logic ee_hit(input logic [7:0] a);
    ee_hit = ({a[7:4], 4'h0} == CPC_BLOCK0_BASE || {a[7:4], 4'h0} == CPC_BLOCK1_BASE)
             && (a[3:2] == 2'b00);
  endfunction

  // Which block the address selects
  function automatic logic ee_blk(input logic [7:0] a);
    ee_blk = ({a[7:4], 4'h0} == CPC_BLOCK1_BASE);
  endfunction

  localparam int unsigned CW = $clog2(COPY_CYC + 1);

  logic       rst_meta_q;            // Reset release, first stage
  logic       rst_n_q;               // Reset release, used by all logic
  logic [8:0] sync_in;               // Comparator bundle before crossing
  logic [8:0] sync_out;              // Comparator bundle after crossing
  logic       s_high;                // Cell above high threshold
  logic       s_resume;              // Cell below resume threshold
  logic       s_low;                 // Cell below low threshold
  logic       s_depl;                // Cell below depletion threshold
  logic       s_drop;                // FET drop above threshold
  logic       s_pack_ok;             // Pack above cell minus drop
  logic       s_chg;                 // Charger detected
  logic       s_hot;                 // Die above temperature limit
  logic       s_sw_n;                // Wake switch, low when pressed
  cpc_mode_e  mode_q;                // Power mode
  logic       wake_q;                // First cycle after waking
  logic       q_high, q_low;         // Qualified cell high / low
  logic       q_depl, q_drop;        // Qualified depletion / FET drop
  logic       wake_go;               // Sleep to active this cycle
  logic       high_blk_q;            // Charge held off by cell high
  logic       low_blk_q;             // Cell-low release pending
  logic       depl_blk_q;            // Drives held off by depletion
  logic       drop_blk_q;            // Drives held off by FET drop
  logic       flag_high_q;           // Cell high flag
  logic       flag_low_q;            // Cell low flag
  logic       flag_exc_q;            // Excess current flag
  logic       flag_ot_q;             // Overtemperature flag
  logic       flag_sw_q;             // Wake switch flag, low after press
  logic       chg_allow_q;           // Host charge allow
  logic       dsg_allow_q;           // Host discharge allow
  logic       lock_en_q;             // Lock command armed
  logic [1:0] locked_q;              // Per-block permanent lock
  logic [7:0] status_q;              // Status bits from stored defaults
  logic [CW-1:0] copy_cnt_q;         // Copy busy countdown
  logic [7:0] shadow_q [2][CPC_BLOCK_BYTES];  // Shadow RAM
  logic [7:0] nvm_q    [2][CPC_BLOCK_BYTES];  // Nonvolatile contents
  logic       wr, rd;                // Write and read strobes
  logic       copy_busy;             // Copy in progress
  logic       hot_any;               // Overtemperature blocks drives
  logic       wr_prot, wr_mem, wr_spec;  // Register write selects

  // Reset release through two flops
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Comparator inputs cross into the clock domain; the switch crosses as
  // pressed-high so the synchroniser's reset zero reads as released, not as a wake
  assign sync_in = {cell_above_high, cell_below_resume, cell_below_low,
                    cell_below_depletion, fet_drop_high, pack_recovered,
                    charger_present, die_overtemp, !wake_switch_input_n};

  cpc_sync #(.W(9)) u_sync
  (
    .clk   (mclk),
    .rst_n (rst_n_q),
    .din   (sync_in),
    .dout  (sync_out)
  );

  // Undo the switch inversion: s_sw_n is low while pressed
  assign {s_high, s_resume, s_low, s_depl, s_drop, s_pack_ok, s_chg, s_hot, s_sw_n}
    = sync_out ^ 9'h001;

  // Qualification timers, running only while active
  cpc_qual_timer #(.CYCLES(CELL_HIGH_CYC)) u_t_high
  (
    .clk       (mclk),
    .rst_n     (rst_n_q),
    .cond      (mode_q == CPC_ACTIVE && s_high),
    .bypass    (wake_q),
    .qualified (q_high)
  );

  cpc_qual_timer #(.CYCLES(CELL_LOW_CYC)) u_t_low
  (
    .clk       (mclk),
    .rst_n     (rst_n_q),
    .cond      (mode_q == CPC_ACTIVE && s_low && !s_depl),
    .bypass    (1'b0),
    .qualified (q_low)
  );

  cpc_qual_timer #(.CYCLES(DEPLETION_CYC)) u_t_depl
  (
    .clk       (mclk),
    .rst_n     (rst_n_q),
    .cond      (mode_q == CPC_ACTIVE && s_depl),
    .bypass    (1'b0),
    .qualified (q_depl)
  );

  cpc_qual_timer #(.CYCLES(FET_DROP_CYC)) u_t_drop
  (
    .clk       (mclk),
    .rst_n     (rst_n_q),
    .cond      (mode_q == CPC_ACTIVE && s_drop),
    .bypass    (1'b0),
    .qualified (q_drop)
  );

  // Command decode
  assign wr        = cmd_valid && cmd_op == CPC_OP_WRITE;
  assign rd        = cmd_valid && cmd_op == CPC_OP_READ;
  assign wr_prot   = wr && cmd_addr == CPC_PROTECTION_CONTROL;
  assign wr_mem    = wr && cmd_addr == CPC_NV_MEMORY_CONTROL;
  assign wr_spec   = wr && cmd_addr == CPC_SPECIAL_FEATURE_CONTROL;
  assign copy_busy = copy_cnt_q != '0;
  assign hot_any   = s_hot || flag_ot_q;
  assign wake_go   = mode_q == CPC_SLEEP && (!s_sw_n || s_chg) && !s_depl;

  // Power mode and the wake marker
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_q <= CPC_SLEEP;
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= wake_go;
      case (mode_q)
        CPC_SLEEP:
          if (wake_go)
            mode_q <= CPC_ACTIVE;
        CPC_ACTIVE:
          if (q_low)
            mode_q <= CPC_SLEEP;
        default:
          mode_q <= CPC_SLEEP;
      endcase
    end
  end

  // Protection lockouts and their release conditions
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      high_blk_q <= 1'b0;
      low_blk_q  <= 1'b0;
      depl_blk_q <= 1'b0;
      drop_blk_q <= 1'b0;
    end
    else
    begin
      if (q_high)
        high_blk_q <= 1'b1;
      else if (s_resume || s_drop)
        high_blk_q <= 1'b0;
      if (q_low)
        low_blk_q <= 1'b1;
      else if (!s_low && s_chg)
        low_blk_q <= 1'b0;
      if (q_depl)
        depl_blk_q <= 1'b1;
      else if (s_pack_ok)
        depl_blk_q <= 1'b0;
      if (q_drop)
        drop_blk_q <= 1'b1;
      else if (s_pack_ok)
        drop_blk_q <= 1'b0;
    end
  end

  // Sticky flags; a hardware set, or for the switch flag a hardware clear, wins over a host write
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flag_high_q <= CPC_RST_CELL_HIGH;
      flag_low_q  <= CPC_RST_CELL_LOW;
      flag_exc_q  <= CPC_RST_EXCESS;
      flag_ot_q   <= CPC_RST_OVERTEMP;
      flag_sw_q   <= CPC_RST_SWITCH;
    end
    else
    begin
      flag_high_q <= q_high || (wr_prot ? cmd_wdata[CPC_BIT_CELL_HIGH] : flag_high_q);
      flag_low_q  <= q_low || (wr_prot ? cmd_wdata[CPC_BIT_CELL_LOW] : flag_low_q);
      flag_exc_q  <= q_depl || q_drop
                     || (wr_prot ? cmd_wdata[CPC_BIT_EXCESS] : flag_exc_q);
      flag_ot_q   <= (mode_q == CPC_ACTIVE && s_hot)
                     || (wr_spec ? cmd_wdata[CPC_BIT_OVERTEMP] : flag_ot_q);
      flag_sw_q   <= s_sw_n && (wr_spec ? cmd_wdata[CPC_BIT_SWITCH] : flag_sw_q);
    end
  end

  // Host allow bits, forced on at wake
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      chg_allow_q <= CPC_RST_CHG_ALLOW;
      dsg_allow_q <= CPC_RST_DSG_ALLOW;
    end
    else if (wake_go)
    begin
      chg_allow_q <= 1'b1;
      dsg_allow_q <= 1'b1;
    end
    else if (wr_prot)
    begin
      chg_allow_q <= cmd_wdata[CPC_BIT_CHG_ALLOW];
      dsg_allow_q <= cmd_wdata[CPC_BIT_DSG_ALLOW];
    end
  end

  // FET drives and the probe and recovery switches
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      charge_drive       <= 1'b0;
      discharge_drive    <= 1'b0;
      probe_current_en   <= 1'b0;
      recovery_charge_en <= 1'b0;
      active_mode        <= 1'b0;
    end
    else
    begin
      charge_drive       <= mode_q == CPC_ACTIVE && chg_allow_q && !q_high && !high_blk_q
                            && !low_blk_q && !depl_blk_q && !drop_blk_q && !hot_any
                            && !q_low && !q_depl && !q_drop;
      discharge_drive    <= mode_q == CPC_ACTIVE && dsg_allow_q && !low_blk_q
                            && !depl_blk_q && !drop_blk_q && !hot_any
                            && !q_low && !q_depl && !q_drop;
      probe_current_en   <= (depl_blk_q && !s_depl) || drop_blk_q;
      recovery_charge_en <= (depl_blk_q && !s_depl)
                            || (mode_q == CPC_ACTIVE && (s_depl || s_resume));
      active_mode        <= mode_q == CPC_ACTIVE;
    end
  end

  // Shadow RAM, nonvolatile copy, locks and status defaults
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int b = 0; b < 2; b++)
        for (int i = 0; i < CPC_BLOCK_BYTES; i++)
        begin
          shadow_q[b][i] <= CPC_RST_MEM;
          nvm_q[b][i]    <= CPC_RST_MEM;
        end
      locked_q   <= 2'b00;
      lock_en_q  <= CPC_RST_LOCK_EN;
      status_q   <= CPC_RST_STATUS;
      copy_cnt_q <= '0;
    end
    else
    begin
      if (copy_busy)
        copy_cnt_q <= copy_cnt_q - CW'(1);
      if (wr_mem)
        lock_en_q <= cmd_wdata[CPC_BIT_LOCK_EN];
      if (wr && ee_hit(cmd_addr) && !locked_q[ee_blk(cmd_addr)] && !copy_busy)
        shadow_q[ee_blk(cmd_addr)][cmd_addr[1:0]] <= cmd_wdata;
      if (cmd_valid && cmd_op == CPC_OP_COPY && ee_hit(cmd_addr)
          && !locked_q[ee_blk(cmd_addr)] && !copy_busy)
      begin
        for (int i = 0; i < CPC_BLOCK_BYTES; i++)
          nvm_q[ee_blk(cmd_addr)][i] <= shadow_q[ee_blk(cmd_addr)][i];
        copy_cnt_q <= CW'(COPY_CYC);
      end
      if (cmd_valid && cmd_op == CPC_OP_RECALL && ee_hit(cmd_addr))
      begin
        for (int i = 0; i < CPC_BLOCK_BYTES; i++)
          shadow_q[ee_blk(cmd_addr)][i] <= nvm_q[ee_blk(cmd_addr)][i];
        if (ee_blk(cmd_addr))
          status_q <= nvm_q[1][CPC_STATUS_INIT_IDX] & CPC_STATUS_MASK;
      end
      if (cmd_valid && cmd_op == CPC_OP_LOCK && ee_hit(cmd_addr) && lock_en_q)
      begin
        locked_q[ee_blk(cmd_addr)] <= 1'b1;
        lock_en_q                  <= 1'b0;
      end
    end
  end

  // One answer per command; reads return data, reserved reads zero
  always_ff @(posedge mclk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end
    else
    begin
      rsp_valid <= cmd_valid;
      rsp_rdata <= 8'h00;
      if (rd)
      begin
        if (ee_hit(cmd_addr))
          rsp_rdata <= shadow_q[ee_blk(cmd_addr)][cmd_addr[1:0]];
        else
          case (cmd_addr)
            CPC_PROTECTION_CONTROL:
              rsp_rdata <= {flag_high_q, flag_low_q, 1'b0, flag_exc_q,
                            charge_drive, discharge_drive,
                            chg_allow_q, dsg_allow_q};
            CPC_DEVICE_STATUS:
              rsp_rdata <= status_q;
            CPC_NV_MEMORY_CONTROL:
              rsp_rdata <= {copy_busy, lock_en_q, 4'h0, locked_q};
            CPC_SPECIAL_FEATURE_CONTROL:
              rsp_rdata <= {flag_sw_q, 6'h00, flag_ot_q};
            default:
              rsp_rdata <= 8'h00;
          endcase
      end
    end
  end

endmodule

// >>> include/cpc_pkg.sv
/*
  Shared constants and types for the cell protection controller: register
  offsets, bit positions, reset values, host command codes and delay times.
  Assumes a 50 MHz system clock; all delay counts derive from it.
*/
package cpc_pkg;

  // System clock rate, in MHz
  localparam int unsigned CPC_CLK_MHZ = 50;

  // Qualification delays, in microseconds
  localparam int unsigned CPC_CELL_HIGH_DELAY_US = 1000;
  localparam int unsigned CPC_CELL_LOW_DELAY_US  = 1000;
  localparam int unsigned CPC_DEPLETION_DELAY_US = 100;
  localparam int unsigned CPC_FET_DROP_DELAY_US  = 100;
  // Time a copy into nonvolatile memory keeps both blocks busy, in microseconds
  localparam int unsigned CPC_COPY_TIME_US       = 2000;

  // Delay counts in clock cycles
  localparam int unsigned CPC_CELL_HIGH_CYC = CPC_CELL_HIGH_DELAY_US * CPC_CLK_MHZ;
  localparam int unsigned CPC_CELL_LOW_CYC  = CPC_CELL_LOW_DELAY_US * CPC_CLK_MHZ;
  localparam int unsigned CPC_DEPLETION_CYC = CPC_DEPLETION_DELAY_US * CPC_CLK_MHZ;
  localparam int unsigned CPC_FET_DROP_CYC  = CPC_FET_DROP_DELAY_US * CPC_CLK_MHZ;
  localparam int unsigned CPC_COPY_CYC      = CPC_COPY_TIME_US * CPC_CLK_MHZ;

  // Register offsets
  localparam logic [7:0] CPC_PROTECTION_CONTROL      = 8'h00;
  localparam logic [7:0] CPC_DEVICE_STATUS           = 8'h01;
  localparam logic [7:0] CPC_NV_MEMORY_CONTROL       = 8'h07;
  localparam logic [7:0] CPC_SPECIAL_FEATURE_CONTROL = 8'h08;
  // Lockable memory blocks, base addresses; each holds four bytes
  localparam logic [7:0] CPC_BLOCK0_BASE = 8'h20;
  localparam logic [7:0] CPC_BLOCK1_BASE = 8'h30;
  localparam int unsigned CPC_BLOCK_BYTES = 4;
  // Byte of block 1 that holds the status defaults
  localparam int unsigned CPC_STATUS_INIT_IDX = 1;

  // Protection register bits
  localparam int unsigned CPC_BIT_CELL_HIGH = 7;
  localparam int unsigned CPC_BIT_CELL_LOW  = 6;
  localparam int unsigned CPC_BIT_EXCESS    = 4;
  localparam int unsigned CPC_BIT_CHG_MIR   = 3;
  localparam int unsigned CPC_BIT_DSG_MIR   = 2;
  localparam int unsigned CPC_BIT_CHG_ALLOW = 1;
  localparam int unsigned CPC_BIT_DSG_ALLOW = 0;
  // Memory control register bits
  localparam int unsigned CPC_BIT_COPY_BUSY = 7;
  localparam int unsigned CPC_BIT_LOCK_EN   = 6;
  localparam int unsigned CPC_BIT_LOCKED1   = 1;
  localparam int unsigned CPC_BIT_LOCKED0   = 0;
  // Special feature register bits
  localparam int unsigned CPC_BIT_SWITCH    = 7;
  localparam int unsigned CPC_BIT_OVERTEMP  = 0;
  // Status bits loaded from the stored defaults
  localparam logic [7:0] CPC_STATUS_MASK = 8'h38;

  // Reset values
  localparam logic       CPC_RST_CELL_HIGH = 1'b0;
  localparam logic       CPC_RST_CELL_LOW  = 1'b1;
  localparam logic       CPC_RST_EXCESS    = 1'b1;
  localparam logic       CPC_RST_CHG_ALLOW = 1'b1;
  localparam logic       CPC_RST_DSG_ALLOW = 1'b1;
  localparam logic       CPC_RST_OVERTEMP  = 1'b0;
  localparam logic       CPC_RST_SWITCH    = 1'b1;
  localparam logic       CPC_RST_LOCK_EN   = 1'b0;
  localparam logic [7:0] CPC_RST_STATUS    = 8'h00;
  localparam logic [7:0] CPC_RST_MEM       = 8'h00;

  // Host commands
  typedef enum logic [2:0]
  {
    CPC_OP_READ,
    CPC_OP_WRITE,
    CPC_OP_COPY,
    CPC_OP_RECALL,
    CPC_OP_LOCK
  } cpc_op_e;

  // Power modes
  typedef enum logic
  {
    CPC_SLEEP,
    CPC_ACTIVE
  } cpc_mode_e;

endpackage

// >>> logic/cpc_sync.sv
/*
  Two-stage synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level; no bundle coherence is promised.
*/
`timescale 1ns/1ns
module cpc_sync
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;  // First stage, read only by the second

  // Two flops in series
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// >>> logic/cpc_qual_timer.sv
/*
  Qualification timer: a condition counts as met once it has stood for
  CYCLES clocks in a row. Any drop of the condition restarts the count.
  A bypass input qualifies the condition at once, with no delay.
*/
`timescale 1ns/1ns
module cpc_qual_timer
#(
  parameter int unsigned CYCLES = 1
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cond,
  input  wire logic bypass,
  output logic      qualified
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] TERM = W'(CYCLES);

  logic [W-1:0] cnt_q;  // Cycles the condition has stood

  // Count while the condition stands, saturate at the terminal count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (!cond)
      cnt_q <= '0;
    else if (cnt_q != TERM)
      cnt_q <= cnt_q + W'(1);
  end

  // Met when held long enough, or at once under bypass
  assign qualified = cond && (bypass || (cnt_q == TERM));

endmodule

// >>> bench/cpc_host.sv
/* Host model: issues one decoded command and takes its response.
   Assumes the controller answers exactly one cycle after taking. */
`timescale 1ns/1ns
module cpc_host
  import cpc_pkg::*;
(
  input  wire logic       mclk,
  output logic            cmd_valid,
  output cpc_pkg::cpc_op_e cmd_op,
  output logic [7:0]      cmd_addr,
  output logic [7:0]      cmd_wdata,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_rdata
);
  // Idle port from time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = CPC_OP_READ;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
  end
  // Hold the command for its taking edge, read the answer one edge later
  task automatic xfer(input cpc_op_e op, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    q = rsp_rdata;
    ok = rsp_valid;
  endtask
endmodule

// >>> bench/cpc_top_monitor.sv
/* Port checker: response timing, mirror bits, drives held off.
   Assumes binding into cpc_top, one clock, reset nrst. */
`timescale 1ns/1ns
module cpc_top_monitor
  import cpc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        die_overtemp,
  input wire logic        cmd_valid,
  input cpc_pkg::cpc_op_e cmd_op,
  input wire logic [7:0]  cmd_addr,
  input wire logic [7:0]  cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_rdata,
  input wire logic        charge_drive,
  input wire logic        discharge_drive,
  input wire logic        probe_current_en,
  input wire logic        active_mode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Host access to the protection register
  logic prot_rd;
  logic prot_wr;
  assign prot_rd = cmd_valid && cmd_op == CPC_OP_READ && cmd_addr == CPC_PROTECTION_CONTROL;
  assign prot_wr = cmd_valid && cmd_op == CPC_OP_WRITE && active_mode && cmd_addr == 8'h00;
  property p_rsp; cmd_valid |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no response");
  property p_idle; !cmd_valid |=> !rsp_valid && rsp_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray response");
  property p_mirror; prot_rd |=> rsp_rdata[5] == 1'b0 && rsp_rdata[3] == $past(charge_drive)
    && rsp_rdata[2] == $past(discharge_drive); endproperty
  a_mirror: assert property (p_mirror) else $error("mirror bits wrong");
  property p_sleep; !active_mode ##1 !active_mode |-> !charge_drive && !discharge_drive;
  endproperty
  a_sleep: assert property (p_sleep) else $error("drive on in sleep");
  property p_hot; die_overtemp [*3] |=> !charge_drive && !discharge_drive; endproperty
  a_hot: assert property (p_hot) else $error("drive on while hot");
  property p_probe; probe_current_en ##1 probe_current_en |-> !discharge_drive; endproperty
  a_probe: assert property (p_probe) else $error("probe with path on");
  property p_chg; prot_wr && !cmd_wdata[1] |-> ##2 !charge_drive; endproperty
  a_chg: assert property (p_chg) else $error("charge not forced off");
  property p_dsg; prot_wr && !cmd_wdata[0] |-> ##2 !discharge_drive; endproperty
  a_dsg: assert property (p_dsg) else $error("discharge not forced off");
endmodule
bind cpc_top cpc_top_monitor i_cpc_top_monitor (.mclk, .nrst, .die_overtemp, .cmd_valid,
  .cmd_op, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_rdata, .charge_drive, .discharge_drive,
  .probe_current_en, .active_mode);

// >>> bench/tb_cell_protection_controller.sv
/* Testbench: register table, wake, cell high, FET drop, depletion, overtemperature,
   memory and cell low. Assumes cpc_top, host model and checker. */
`timescale 1ns/1ns
module tb_cell_protection_controller;
  import cpc_pkg::*;
  typedef struct {cpc_op_e op; logic [7:0] a; logic [7:0] d; logic [7:0] e;} cpc_row_s;
  logic mclk, nrst, cell_above_high, cell_below_resume, cell_below_low, cell_below_depletion;
  logic fet_drop_high, pack_recovered, charger_present, die_overtemp, wake_switch_input_n;
  logic cmd_valid, rsp_valid, charge_drive, discharge_drive, probe_current_en;
  logic recovery_charge_en, active_mode;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata;
  cpc_op_e    cmd_op;
  int         error_cnt = 0;
  int         checks = 0;
  // Register table rows while asleep after reset
  cpc_row_s   rows [10] = '{'{CPC_OP_READ, 8'h00, 8'h00, 8'h53},
    '{CPC_OP_READ, 8'h01, 8'h00, 8'h00}, '{CPC_OP_READ, 8'h07, 8'h00, 8'h00},
    '{CPC_OP_READ, 8'h08, 8'h00, 8'h80}, '{CPC_OP_READ, 8'h05, 8'h00, 8'h00},
    '{CPC_OP_READ, 8'hC0, 8'h00, 8'h00}, '{CPC_OP_WRITE, 8'h01, 8'hFF, 8'h00},
    '{CPC_OP_READ, 8'h01, 8'h00, 8'h00}, '{CPC_OP_WRITE, 8'h22, 8'hA5, 8'h00},
    '{CPC_OP_READ, 8'h22, 8'h00, 8'hA5}};
  cpc_top #(.CELL_HIGH_CYC(8), .CELL_LOW_CYC(8), .DEPLETION_CYC(6), .FET_DROP_CYC(6),
    .COPY_CYC(10)) i_cpc_top (.*);
  cpc_host i_cpc_host (.*);
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One command with its expected answer
  task automatic cmd(input cpc_op_e op, input logic [7:0] a, d, e);
    logic [7:0] q;
    logic       ok;
    i_cpc_host.xfer(op, a, d, q, ok);
    chk(q, e);
    chk({7'h0, ok}, 8'h01);
  endtask
  // Bounded wait for an output level
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 60)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, s}, {7'h0, v});
    if (s !== v) report_and_stop();
  endtask
  // Poll the copy-busy bit until it clears
  task automatic poll_copy();
    logic [7:0] q;
    logic       ok;
    int         n;
    n = 0;
    q = 8'h80;
    while (q[7] && n < 20)
    begin
      i_cpc_host.xfer(CPC_OP_READ, CPC_NV_MEMORY_CONTROL, 8'h00, q, ok);
      n++;
    end
    chk({7'h0, q[7]}, 8'h00);
    if (q[7]) report_and_stop();
  endtask
  task automatic stp(input string s);
    $display("test %s done", s);
  endtask
  initial
  begin
    nrst = 1'b0;
    {cell_above_high, cell_below_resume, cell_below_low, cell_below_depletion} = 4'h0;
    {fet_drop_high, charger_present, die_overtemp} = 3'h0;
    pack_recovered = 1'b1;
    wake_switch_input_n = 1'b1;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i]) cmd(rows[i].op, rows[i].a, rows[i].d, rows[i].e);
    stp("table");
    cmd(CPC_OP_WRITE, 8'h00, 8'h50, 8'h00);
    wake_switch_input_n <= 1'b0;
    wait_lvl(active_mode, 1'b1);
    wake_switch_input_n <= 1'b1;
    wait_lvl(discharge_drive, 1'b1);
    cmd(CPC_OP_READ, 8'h00, 8'h00, 8'h5F);
    cmd(CPC_OP_READ, 8'h08, 8'h00, 8'h00);
    cmd(CPC_OP_WRITE, 8'h00, 8'h00, 8'h00);
    wait_lvl(charge_drive, 1'b0);
    cmd(CPC_OP_WRITE, 8'h00, 8'h03, 8'h00);
    wait_lvl(charge_drive, 1'b1);
    stp("wake");
    cell_above_high <= 1'b1;
    wait_lvl(charge_drive, 1'b0);
    chk({7'h0, discharge_drive}, 8'h01);
    cell_above_high <= 1'b0;
    cell_below_resume <= 1'b1;
    wait_lvl(charge_drive, 1'b1);
    chk({7'h0, recovery_charge_en}, 8'h01);
    cmd(CPC_OP_READ, 8'h00, 8'h00, 8'h8F);
    cell_below_resume <= 1'b0;
    cmd(CPC_OP_WRITE, 8'h00, 8'h03, 8'h00);
    stp("cell high");
    pack_recovered <= 1'b0;
    fet_drop_high <= 1'b1;
    wait_lvl(discharge_drive, 1'b0);
    @(posedge mclk);
    chk({6'h0, charge_drive, probe_current_en}, 8'h01);
    fet_drop_high <= 1'b0;
    pack_recovered <= 1'b1;
    wait_lvl(discharge_drive, 1'b1);
    cmd(CPC_OP_READ, 8'h00, 8'h00, 8'h1F);
    cmd(CPC_OP_WRITE, 8'h00, 8'h03, 8'h00);
    stp("fet drop");
    pack_recovered <= 1'b0;
    cell_below_depletion <= 1'b1;
    wait_lvl(discharge_drive, 1'b0);
    cell_below_depletion <= 1'b0;
    wait_lvl(probe_current_en, 1'b1);
    chk({6'h0, recovery_charge_en, charge_drive}, 8'h02);
    pack_recovered <= 1'b1;
    wait_lvl(discharge_drive, 1'b1);
    cmd(CPC_OP_WRITE, 8'h00, 8'h03, 8'h00);
    stp("depletion");
    die_overtemp <= 1'b1;
    wait_lvl(charge_drive, 1'b0);
    die_overtemp <= 1'b0;
    repeat (12) @(posedge mclk);
    chk({6'h0, charge_drive, discharge_drive}, 8'h00);
    cmd(CPC_OP_READ, 8'h08, 8'h00, 8'h01);
    cmd(CPC_OP_WRITE, 8'h08, 8'h00, 8'h00);
    wait_lvl(charge_drive, 1'b1);
    stp("overtemp");
    cmd(CPC_OP_WRITE, 8'h31, 8'hFF, 8'h00);
    cmd(CPC_OP_COPY, 8'h30, 8'h00, 8'h00);
    poll_copy();
    cmd(CPC_OP_WRITE, 8'h31, 8'h00, 8'h00);
    cmd(CPC_OP_RECALL, 8'h30, 8'h00, 8'h00);
    cmd(CPC_OP_READ, 8'h31, 8'h00, 8'hFF);
    cmd(CPC_OP_READ, 8'h01, 8'h00, 8'h38);
    cmd(CPC_OP_WRITE, 8'h07, 8'h40, 8'h00);
    cmd(CPC_OP_LOCK, 8'h30, 8'h00, 8'h00);
    cmd(CPC_OP_READ, 8'h07, 8'h00, 8'h02);
    cmd(CPC_OP_WRITE, 8'h31, 8'h00, 8'h00);
    cmd(CPC_OP_READ, 8'h31, 8'h00, 8'hFF);
    stp("memory");
    cell_below_low <= 1'b1;
    wait_lvl(active_mode, 1'b0);
    chk({6'h0, charge_drive, discharge_drive}, 8'h00);
    cell_below_low <= 1'b0;
    cell_above_high <= 1'b1;
    charger_present <= 1'b1;
    wait_lvl(active_mode, 1'b1);
    repeat (3) @(posedge mclk);
    chk({7'h0, charge_drive}, 8'h00);
    cell_above_high <= 1'b0;
    cell_below_resume <= 1'b1;
    wait_lvl(charge_drive, 1'b1);
    cmd(CPC_OP_READ, 8'h00, 8'h00, 8'hCF);
    stp("cell low");
    report_and_stop();
  end
endmodule
